// file: isr_checker.sv
// Port checks of the status reporting core.
`timescale 1ns/100ps
`default_nettype none
module isr_checker (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       acquisition_idle,
    input wire logic       out_buf_nonempty,
    input wire logic       cmd_valid,
    input wire logic [2:0] cmd_target,
    input wire logic       cmd_write,
    input wire logic       cmd_clear,
    input wire logic       cmd_trigger,
    input wire logic       cmd_has_index,
    input wire logic [7:0] cmd_value,
    input wire logic       cmd_ready,
    input wire logic       rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic [7:0] serial_poll_out,
    input wire logic       srq_out,
    input wire logic       psc_out
);
    logic q_take;
    logic w_take;
    ////////////////////////////////////////
    // Actions never answer, so only plain queries expect data.
    assign w_take = cmd_valid && cmd_ready && (cmd_write || cmd_clear || cmd_trigger);
    assign q_take = cmd_valid && cmd_ready && !(cmd_write || cmd_clear || cmd_trigger);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    AST_QUERY_ANSWER: assert property (q_take |=> rsp_valid)
        else $error("query not answered");
    AST_ACTION_SILENT: assert property (w_take |=> !rsp_valid)
        else $error("action answered");
    AST_INDEX_ONE_BIT: assert property (q_take && cmd_has_index |=> rsp_data[7:1] == 7'h00)
        else $error("bit query too wide");
    AST_POLL_BIT7_ZERO: assert property (!serial_poll_out[7])
        else $error("poll bit 7 set");
    AST_ACQ_IDLE_SHOWN: assert property ($rose(acquisition_idle) |-> ##[1:6] serial_poll_out[0])
        else $error("idle bit missing");
    AST_MAV_SET: assert property ($rose(out_buf_nonempty) |-> ##[1:6] serial_poll_out[4])
        else $error("data bit missing");
    AST_MAV_CLEAR: assert property ($fell(out_buf_nonempty) |-> ##[1:6] !serial_poll_out[4])
        else $error("data bit stuck");
    AST_SRQ_IN_POLL: assert property ($rose(srq_out) |-> ##[0:3] serial_poll_out[6])
        else $error("request bit missing");
    AST_PSC_CLEAR: assert property (w_take && cmd_write && !cmd_trigger && cmd_target == 3'h4 && !cmd_value[0]
        && !cmd_clear |=> ##[0:1] !psc_out)
        else $error("clear flag kept");
    cover property (q_take && cmd_has_index);
    cover property ($rose(srq_out));
    cover property (w_take && cmd_clear);
endmodule : isr_checker
bind isr_top isr_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .acquisition_idle(acquisition_idle),
    .out_buf_nonempty(out_buf_nonempty), .cmd_valid(cmd_valid), .cmd_target(cmd_target), .cmd_write(cmd_write),
    .cmd_clear(cmd_clear), .cmd_trigger(cmd_trigger), .cmd_has_index(cmd_has_index), .cmd_value(cmd_value),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .serial_poll_out(serial_poll_out),
    .srq_out(srq_out), .psc_out(psc_out));
`default_nettype wire

// file: isr_host.sv
// Host computer model issuing status commands.
`timescale 1ns/100ps
`default_nettype none
module isr_host (
    input  wire logic       core_clk,
    input  wire logic       cmd_ready,
    output logic            cmd_valid,
    output logic      [2:0] cmd_target,
    output logic            cmd_write,
    output logic            cmd_clear,
    output logic            cmd_trigger,
    output logic            cmd_has_index,
    output logic      [2:0] cmd_index,
    output logic      [7:0] cmd_value
);
    ////////////////////////////////////////
    // Quiet bus at time zero.
    initial begin
        {cmd_valid, cmd_write, cmd_clear, cmd_trigger, cmd_has_index} = 5'h00;
        {cmd_target, cmd_index, cmd_value} = 14'h0000;
    end
    // Held until taken or 20 cycles pass; on release index and value are inverted so stale values never pass.
    task automatic send(input logic [2:0] t, input logic w, input logic c, input logic g,
                        input logic h, input logic [2:0] i, input logic [7:0] v);
        int n = 0;
        @(posedge core_clk);
        #1;
        {cmd_target, cmd_write, cmd_clear, cmd_trigger} = {t, w, c, g};
        {cmd_has_index, cmd_index, cmd_value} = {h, i, v};
        cmd_valid = 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 20);
        #1;
        cmd_valid = 1'b0;
        {cmd_index, cmd_value} = ~{cmd_index, cmd_value};
    endtask : send
endmodule : isr_host
`default_nettype wire

// file: isr_pkg.sv
// Package with constants and types of the instrument status reporting block.
package isr_pkg;

    // Serial poll summary byte bit positions.
    localparam int ISR_SP_ACQ_IDLE  = 0;
    localparam int ISR_SP_CMD_IDLE  = 1;
    localparam int ISR_SP_FAULT     = 2;
    localparam int ISR_SP_MEAS      = 3;
    localparam int ISR_SP_MAV       = 4;
    localparam int ISR_SP_EVENT     = 5;
    localparam int ISR_SP_SRQ       = 6;

    // Standard event byte bit positions.
    localparam int ISR_EV_INQ_OVF   = 0;
    localparam int ISR_EV_OUTQ_OVF  = 2;
    localparam int ISR_EV_EXEC      = 4;
    localparam int ISR_EV_ILLEGAL   = 5;
    localparam int ISR_EV_USER      = 6;
    localparam int ISR_EV_PON       = 7;
    localparam logic [7:0] ISR_EV_USED = 8'hf5;

    // Measurement status byte bit positions.
    localparam int ISR_MS_RSV_INP   = 0;
    localparam int ISR_MS_FILTER    = 1;
    localparam int ISR_MS_OUTPUT    = 2;
    localparam int ISR_MS_UNLOCK    = 3;
    localparam int ISR_MS_RANGE     = 4;
    localparam int ISR_MS_TC        = 5;
    localparam int ISR_MS_TRIG      = 6;
    localparam logic [7:0] ISR_MS_USED = 8'h7f;

    // Fault status byte bit positions.
    localparam int ISR_FS_BACKUP    = 1;
    localparam int ISR_FS_RAM       = 2;
    localparam int ISR_FS_ROM       = 4;
    localparam int ISR_FS_BUS_ABORT = 5;
    localparam int ISR_FS_DSP       = 6;
    localparam int ISR_FS_MATH      = 7;
    localparam logic [7:0] ISR_FS_USED = 8'hf6;

    // Values after reset.
    localparam logic [7:0] ISR_MASK_RST = 8'h00;
    localparam logic [7:0] ISR_BYTE_RST = 8'h00;
    localparam logic       ISR_PSC_RST  = 1'b1;

    // Detection frequency boundary in hertz.
    localparam int ISR_RANGE_HZ = 200;

    // Targets of a status command.
    typedef enum logic [2:0] {
        ISR_TGT_EVENT  = 3'h0,
        ISR_TGT_EVMASK = 3'h1,
        ISR_TGT_SPOLL  = 3'h2,
        ISR_TGT_SPMASK = 3'h3,
        ISR_TGT_PSC    = 3'h4,
        ISR_TGT_FMASK  = 3'h5,
        ISR_TGT_MEAS   = 3'h6,
        ISR_TGT_FAULT  = 3'h7
    } isr_target_t;

    // Command state machine, Gray coded along idle, run, answer.
    typedef enum logic [1:0] {
        ISR_ST_IDLE   = 2'b00,
        ISR_ST_RUN    = 2'b01,
        ISR_ST_ANSWER = 2'b11
    } isr_state_t;

endpackage : isr_pkg

// file: isr_src_if.sv
// Interface carrying synchronised event sources to the status core.
`timescale 1ns/100ps
`default_nettype none
interface isr_src_if;
    logic [7:0] ev_raw;
    logic [7:0] ms_raw;
    logic [7:0] fs_raw;
    logic       acq_idle;
    logic       cmd_idle;
    logic       mav;
    modport src (output ev_raw, ms_raw, fs_raw, acq_idle, cmd_idle, mav);
    modport dst (input ev_raw, ms_raw, fs_raw, acq_idle, cmd_idle, mav);
endinterface : isr_src_if
`default_nettype wire

// file: isr_sync.sv
// Input synchroniser and edge catcher for the event source pins.
`timescale 1ns/100ps
`default_nettype none
module isr_sync #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out,
    output logic      [W-1:0] rise_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] last_q;

    // Two stages; only the second stage is looked at by the edge logic.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign rise_out  = sync_q & ~last_q;
endmodule : isr_sync
`default_nettype wire

// file: isr_top.sv
// Status reporting core: status bytes, enable masks, summaries and commands.
//
// Overview of operation
// - Clear-status command clears event, measurement and fault bytes and drops the service request.
// - Event mask is written as a byte or one bit, read whole or per bit.
// - Event byte query returns the whole byte or the one indexed bit.
// - Serial poll mask is written as a byte or one bit, read either way.
// - Serial poll query returns the whole byte or the one indexed bit.
// - Power-on status clear flag is written and read, one means set.
// - Fault mask is written as a byte or one bit, read either way.
// - Poll bit 0 shows acquisition idle, bit 1 shows command idle.
// - Poll bit 2 is set while any enabled fault bit is set.
// - Poll bit 3 is set while any measurement bit is set; there is no measurement mask.
// - Poll bit 4 is set while the synchronised output buffer level shows unread data.
// - Poll bit 5 is set while any enabled event bit is set.
// - Poll bit 6 shows a raised service request; bit 7 reads zero.
// - Event bit 0 on input overflow, bit 2 on output overflow.
// - Event bit 4 on execution fault, bit 5 on illegal command.
// - Event bit 6 on key or knob activity, bit 7 at power-on.
// - Measurement bits 0 to 3 flag the overload and unlock conditions.
// - Measurement bit 4 sets when detection frequency crosses 200 Hz.
// - Measurement bit 5 on time constant change, bit 6 on trigger.
// - Software trigger command acts like a hardware trigger edge.
// - Fault byte flags battery, memory, processor and math failures.
// - Fault bit 5 sets when a bus binary transfer aborts.
`timescale 1ns/100ps
`default_nettype none
module isr_top
    import isr_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       acquisition_idle,
    input  wire logic       command_idle,
    input  wire logic       out_buf_nonempty,
    input  wire logic       input_queue_overflow,
    input  wire logic       output_queue_overflow,
    input  wire logic       execution_fault,
    input  wire logic       illegal_command,
    input  wire logic       user_request,
    input  wire logic       reserve_input_overload,
    input  wire logic       filter_overload,
    input  wire logic       output_overload,
    input  wire logic       reference_unlock,
    input  wire logic       freq_above_range,
    input  wire logic       time_constant_changed,
    input  wire logic       trigger_in,
    input  wire logic       backup_fail,
    input  wire logic       ram_fail,
    input  wire logic       rom_fail,
    input  wire logic       bus_abort,
    input  wire logic       dsp_fail,
    input  wire logic       math_fail,
    input  wire logic       cmd_valid,
    input  wire logic [2:0] cmd_target,
    input  wire logic       cmd_write,
    input  wire logic       cmd_clear,
    input  wire logic       cmd_trigger,
    input  wire logic       cmd_has_index,
    input  wire logic [2:0] cmd_index,
    input  wire logic [7:0] cmd_value,
    output logic            cmd_ready,
    output logic            rsp_valid,
    output logic      [7:0] rsp_data,
    output logic      [7:0] serial_poll_out,
    output logic            srq_out,
    output logic            psc_out
);

    //////////////////////////////////////////////////////////////////////////
    // Synchronisers and edge detection.

    logic [7:0]  ev_lvl;
    logic [7:0]  ev_rise;
    logic [7:0]  ms_lvl;
    logic [7:0]  ms_rise;
    logic [7:0]  fs_lvl;
    logic [7:0]  fs_rise;
    logic [2:0]  misc_lvl;
    logic [2:0]  misc_rise;
    logic        range_prev_q;
    logic        pon_q;
    isr_src_if   src ();

    isr_sync #(.W(8)) u_sync_ev (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_in    ({1'b0, user_request, illegal_command, execution_fault, 1'b0,
                     output_queue_overflow, 1'b0, input_queue_overflow}),
        .level_out (ev_lvl),
        .rise_out  (ev_rise)
    );

    isr_sync #(.W(8)) u_sync_ms (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_in    ({1'b0, trigger_in, time_constant_changed, freq_above_range,
                     reference_unlock, output_overload, filter_overload, reserve_input_overload}),
        .level_out (ms_lvl),
        .rise_out  (ms_rise)
    );

    isr_sync #(.W(8)) u_sync_fs (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_in    ({math_fail, dsp_fail, bus_abort, rom_fail, 1'b0, ram_fail, backup_fail, 1'b0}),
        .level_out (fs_lvl),
        .rise_out  (fs_rise)
    );

    isr_sync #(.W(3)) u_sync_misc (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_in    ({out_buf_nonempty, command_idle, acquisition_idle}),
        .level_out (misc_lvl),
        .rise_out  (misc_rise)
    );

    // Range crossing needs both edges, so keep the last synchronised level.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            range_prev_q <= 1'b0;
        end else begin
            range_prev_q <= ms_lvl[ISR_MS_RANGE];
        end
    end

    // Events are taken on rising edges, the range bit on either edge.
    assign src.ev_raw   = ev_rise & ISR_EV_USED;
    assign src.ms_raw   = ((ms_rise & ~(8'h01 << ISR_MS_RANGE))
                          | ({7'h00, ms_lvl[ISR_MS_RANGE] ^ range_prev_q} << ISR_MS_RANGE)) & ISR_MS_USED;
    assign src.fs_raw   = fs_rise & ISR_FS_USED;
    assign src.acq_idle = misc_lvl[0];
    assign src.cmd_idle = misc_lvl[1];
    assign src.mav      = misc_lvl[2];

    //////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Writes a whole byte or one indexed bit.
    function automatic logic [7:0] put_byte(input logic [7:0] old, input logic has_idx,
                                            input logic [2:0] idx, input logic [7:0] val);
        logic [7:0] res;
        res = old;
        if (has_idx) begin
            res[idx] = val[0];
        end else begin
            res = val;
        end
        return res;
    endfunction : put_byte

    // Reads a whole byte or one indexed bit into bit 0.
    function automatic logic [7:0] get_byte(input logic [7:0] cur, input logic has_idx,
                                            input logic [2:0] idx);
        logic [7:0] res;
        res = cur;
        if (has_idx) begin
            res = {7'h00, cur[idx]};
        end
        return res;
    endfunction : get_byte

    //////////////////////////////////////////////////////////////////////////
    // Command decode.

    isr_state_t  state_q;
    logic        cmd_take;
    logic        wr_evmask;
    logic        wr_spmask;
    logic        wr_fmask;
    logic        wr_psc;
    logic        clr_all;
    logic        sw_trig;
    logic        rd_event;
    logic        rd_meas;
    logic        rd_fault;
    logic        rd_spoll;

    assign cmd_take  = cmd_valid && cmd_ready;
    assign clr_all   = cmd_take && cmd_clear;
    assign sw_trig   = cmd_take && cmd_trigger && !cmd_clear;
    assign wr_evmask = cmd_take && !cmd_clear && !cmd_trigger && cmd_write && cmd_target == ISR_TGT_EVMASK;
    assign wr_spmask = cmd_take && !cmd_clear && !cmd_trigger && cmd_write && cmd_target == ISR_TGT_SPMASK;
    assign wr_fmask  = cmd_take && !cmd_clear && !cmd_trigger && cmd_write && cmd_target == ISR_TGT_FMASK;
    assign wr_psc    = cmd_take && !cmd_clear && !cmd_trigger && cmd_write && cmd_target == ISR_TGT_PSC;
    assign rd_event  = cmd_take && !cmd_clear && !cmd_trigger && !cmd_write && cmd_target == ISR_TGT_EVENT;
    assign rd_meas   = cmd_take && !cmd_clear && !cmd_trigger && !cmd_write && cmd_target == ISR_TGT_MEAS;
    assign rd_fault  = cmd_take && !cmd_clear && !cmd_trigger && !cmd_write && cmd_target == ISR_TGT_FAULT;
    assign rd_spoll  = cmd_take && !cmd_clear && !cmd_trigger && !cmd_write && cmd_target == ISR_TGT_SPOLL;

    //////////////////////////////////////////////////////////////////////////
    // Masks and power-on clear flag.

    logic [7:0] ev_mask_q;
    logic [7:0] sp_mask_q;
    logic [7:0] f_mask_q;
    logic       psc_q;

    // Masks keep their value across a clear-status, only writes change them.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_mask_q <= ISR_MASK_RST;
            sp_mask_q <= ISR_MASK_RST;
            f_mask_q  <= ISR_MASK_RST;
            psc_q     <= ISR_PSC_RST;
        end else begin
            if (wr_evmask) begin
                ev_mask_q <= put_byte(ev_mask_q, cmd_has_index, cmd_index, cmd_value);
            end
            if (wr_spmask) begin
                sp_mask_q <= put_byte(sp_mask_q, cmd_has_index, cmd_index, cmd_value) & 8'hbf;
            end
            if (wr_fmask) begin
                f_mask_q <= put_byte(f_mask_q, cmd_has_index, cmd_index, cmd_value);
            end
            if (wr_psc) begin
                psc_q <= cmd_value[0];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Sticky event bytes; a new event wins over a clear in the same cycle.

    logic [7:0] ev_q;
    logic [7:0] ms_q;
    logic [7:0] fs_q;
    logic [7:0] ms_set;

    assign ms_set = src.ms_raw | ({7'h00, sw_trig} << ISR_MS_TRIG);

    // Power-on sets event bit 7 on the first clock after reset release.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pon_q <= 1'b1;
        end else begin
            pon_q <= 1'b0;
        end
    end

    // Reading an event byte empties it, as a standard event register does.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_q <= ISR_BYTE_RST;
        end else begin
            ev_q <= ((clr_all || rd_event) ? 8'h00 : ev_q) | src.ev_raw
                    | ({7'h00, pon_q} << ISR_EV_PON);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_q <= ISR_BYTE_RST;
        end else begin
            ms_q <= ((clr_all || rd_meas) ? 8'h00 : ms_q) | ms_set;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fs_q <= ISR_BYTE_RST;
        end else begin
            fs_q <= ((clr_all || rd_fault) ? 8'h00 : fs_q) | src.fs_raw;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Serial poll summary byte and service request.

    logic [7:0] sp_d;
    logic [7:0] sp_q;
    logic       srq_q;
    logic       srq_cond;

    // Summary bits follow their sources live; only the request bit is sticky.
    always_comb begin
        sp_d                = 8'h00;
        sp_d[ISR_SP_ACQ_IDLE] = src.acq_idle;
        sp_d[ISR_SP_CMD_IDLE] = src.cmd_idle;
        sp_d[ISR_SP_FAULT]  = |(fs_q & f_mask_q);
        sp_d[ISR_SP_MEAS]   = |(ms_q & ISR_MS_USED);
        sp_d[ISR_SP_MAV]    = src.mav;
        sp_d[ISR_SP_EVENT]  = |(ev_q & ev_mask_q);
        sp_d[ISR_SP_SRQ]    = srq_q;
    end

    assign srq_cond = |(sp_d & sp_mask_q & 8'hbf);

    // A clear-status drops the request; a cause still present raises it again next cycle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            srq_q <= 1'b0;
        end else begin
            srq_q <= clr_all ? 1'b0 : (srq_q | srq_cond);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_q <= ISR_BYTE_RST;
        end else begin
            sp_q <= sp_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Command handshake and answer.

    // One command at a time: accept, then answer one cycle later.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ISR_ST_IDLE;
        end else begin
            case (state_q)
                ISR_ST_IDLE:   state_q <= ISR_ST_RUN;
                ISR_ST_RUN:    state_q <= cmd_take ? ISR_ST_ANSWER : ISR_ST_RUN;
                ISR_ST_ANSWER: state_q <= ISR_ST_RUN;
                default:       state_q <= ISR_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ready <= 1'b0;
        end else begin
            cmd_ready <= (state_q == ISR_ST_IDLE || state_q == ISR_ST_ANSWER)
                         || (state_q == ISR_ST_RUN && !cmd_take);
        end
    end

    // Queries of the event bytes return the value held before the read clears it.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h00;
        end else begin
            rsp_valid <= cmd_take && !cmd_clear && !cmd_trigger && !cmd_write;
            rsp_data  <= 8'h00;
            if (cmd_take && !cmd_clear && !cmd_trigger && !cmd_write) begin
                case (cmd_target)
                    ISR_TGT_EVENT:  rsp_data <= get_byte(ev_q, cmd_has_index, cmd_index);
                    ISR_TGT_EVMASK: rsp_data <= get_byte(ev_mask_q, cmd_has_index, cmd_index);
                    ISR_TGT_SPOLL:  rsp_data <= get_byte(sp_d, cmd_has_index, cmd_index);
                    ISR_TGT_SPMASK: rsp_data <= get_byte(sp_mask_q, cmd_has_index, cmd_index);
                    ISR_TGT_PSC:    rsp_data <= {7'h00, psc_q};
                    ISR_TGT_FMASK:  rsp_data <= get_byte(f_mask_q, cmd_has_index, cmd_index);
                    ISR_TGT_MEAS:   rsp_data <= get_byte(ms_q, cmd_has_index, cmd_index);
                    ISR_TGT_FAULT:  rsp_data <= get_byte(fs_q, cmd_has_index, cmd_index);
                    default:        rsp_data <= 8'h00;
                endcase
            end
        end
    end

    // Status pins for the bus side.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_poll_out <= 8'h00;
            srq_out         <= 1'b0;
            psc_out         <= ISR_PSC_RST;
        end else begin
            serial_poll_out <= sp_q;
            srq_out         <= srq_q;
            psc_out         <= psc_q;
        end
    end

    // Poll read does not clear; the poll byte itself is rebuilt every cycle.
    logic unused_rd;
    assign unused_rd = rd_spoll ^ (|misc_rise) ^ ms_lvl[7] ^ ev_lvl[0] ^ fs_lvl[0];

endmodule : isr_top
`default_nettype wire

// file: isr_top_tb.sv
// Self-checking testbench of the status reporting core.
`timescale 1ns/100ps
`default_nettype none
module isr_top_tb;
    import isr_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        acq      = 1'b0;
    logic        cidle    = 1'b1;
    logic        mav      = 1'b0;
    logic [17:0] src      = '0;
    logic        cmd_valid, cmd_write, cmd_clear, cmd_trigger, cmd_has_index;
    logic        cmd_ready, rsp_valid, srq_out, psc_out;
    logic [2:0]  cmd_target, cmd_index;
    logic [7:0]  cmd_value, rsp_data, serial_poll_out;
    logic [7:0]  exp_q [$];
    int          fail_count = 0;
    int          checks     = 0;
    localparam int POS [18] = '{0, 2, 4, 5, 6, 0, 1, 2, 3, 4, 5, 6, 1, 2, 4, 5, 6, 7};
    ////////////////////////////////////////
    always #4 core_clk = ~core_clk;
    isr_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .acquisition_idle(acq), .command_idle(cidle),
        .out_buf_nonempty(mav), .input_queue_overflow(src[0]), .output_queue_overflow(src[1]),
        .execution_fault(src[2]), .illegal_command(src[3]), .user_request(src[4]),
        .reserve_input_overload(src[5]), .filter_overload(src[6]), .output_overload(src[7]),
        .reference_unlock(src[8]), .freq_above_range(src[9]), .time_constant_changed(src[10]),
        .trigger_in(src[11]), .backup_fail(src[12]), .ram_fail(src[13]), .rom_fail(src[14]),
        .bus_abort(src[15]), .dsp_fail(src[16]), .math_fail(src[17]), .cmd_valid(cmd_valid),
        .cmd_target(cmd_target), .cmd_write(cmd_write), .cmd_clear(cmd_clear), .cmd_trigger(cmd_trigger),
        .cmd_has_index(cmd_has_index), .cmd_index(cmd_index), .cmd_value(cmd_value), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .serial_poll_out(serial_poll_out), .srq_out(srq_out),
        .psc_out(psc_out));
    isr_host u_host (.core_clk(core_clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_target(cmd_target),
        .cmd_write(cmd_write), .cmd_clear(cmd_clear), .cmd_trigger(cmd_trigger), .cmd_has_index(cmd_has_index),
        .cmd_index(cmd_index), .cmd_value(cmd_value));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // The expectation is queued before the query goes out.
    task automatic ask(input logic [2:0] t, input logic h, input logic [2:0] i, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.send(t, 1'b0, 1'b0, 1'b0, h, i, 8'h00);
    endtask : ask
    task automatic wr(input logic [2:0] t, input logic h, input logic [2:0] i, input logic [7:0] v);
        u_host.send(t, 1'b1, 1'b0, 1'b0, h, i, v);
    endtask : wr
    task automatic stop_test;
        if (exp_q.size() != 0) fail_count++;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    // Answers are matched against the oldest note.
    always @(posedge core_clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) fail_count++;
            else check(rsp_data, exp_q.pop_front());
        end
    end
    initial begin
        #100000;
        fail_count++;
        stop_test();
    end
    initial begin
        logic [2:0] tg [3];
        logic [7:0] v;
        int         b;
        tg = '{ISR_TGT_EVMASK, ISR_TGT_SPMASK, ISR_TGT_FMASK};
        void'($urandom(46));
        repeat (12) @(posedge core_clk);
        #1 rst_n = 1'b1;
        ask(ISR_TGT_EVENT, 1'b0, 3'h0, 8'h80);
        ask(ISR_TGT_EVENT, 1'b0, 3'h0, 8'h00);
        ask(ISR_TGT_PSC, 1'b0, 3'h0, 8'h01);
        wr(ISR_TGT_PSC, 1'b0, 3'h0, 8'h00);
        ask(ISR_TGT_PSC, 1'b0, 3'h0, 8'h00);
        // Masks: whole byte, then one bit flipped by index; poll bit 6 never sticks.
        for (int m = 0; m < 3; m++) begin
            v = 8'($urandom);
            b = $urandom_range(7);
            wr(tg[m], 1'b0, 3'h0, v);
            if (m == 1) v[6] = 1'b0;
            ask(tg[m], 1'b0, 3'h0, v);
            v[b] = ~v[b];
            wr(tg[m], 1'b1, 3'(b), {7'h00, v[b]});
            if (m == 1) v[6] = 1'b0;
            ask(tg[m], 1'b1, 3'(b), {7'h00, v[b]});
            ask(tg[m], 1'b0, 3'h0, v);
            wr(tg[m], 1'b0, 3'h0, 8'h00);
        end
        // Rising edges set bits; falling ones only move the frequency bit.
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 18; k++) begin
                @(posedge core_clk);
                #1 src[k] = ~src[k];
                repeat (6) @(posedge core_clk);
                v = (p == 0 || k == 9) ? 8'h01 << POS[k] : 8'h00;
                ask(k < 5 ? ISR_TGT_EVENT : k < 12 ? ISR_TGT_MEAS : ISR_TGT_FAULT, 1'b0, 3'h0, v);
            end
        end
        u_host.send(3'h0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 8'h00);
        repeat (4) @(posedge core_clk);
        ask(ISR_TGT_MEAS, 1'b0, 3'h0, 8'h40);
        wr(ISR_TGT_FMASK, 1'b0, 3'h0, 8'h20);
        wr(ISR_TGT_EVMASK, 1'b0, 3'h0, 8'h10);
        wr(ISR_TGT_SPMASK, 1'b0, 3'h0, 8'h04);
        @(posedge core_clk) #1 {acq, cidle, mav} = {1'b1, 1'($urandom), 1'b1};
        {src[15], src[5], src[2]} = 3'h7;
        repeat (8) @(posedge core_clk);
        v = {7'b0111111, acq};
        v[1] = cidle;
        for (int i = 0; i < 8; i++) ask(ISR_TGT_SPOLL, 1'b1, 3'(i), {7'h00, v[i]});
        check({7'h00, srq_out}, 8'h01);
        check(serial_poll_out, v);
        ask(ISR_TGT_EVENT, 1'b1, 3'h4, 8'h01);
        u_host.send(3'h0, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00);
        @(posedge core_clk) #1 mav = 1'b0;
        repeat (8) @(posedge core_clk);
        ask(ISR_TGT_FAULT, 1'b0, 3'h0, 8'h00);
        ask(ISR_TGT_MEAS, 1'b0, 3'h0, 8'h00);
        ask(ISR_TGT_SPOLL, 1'b1, 3'h2, 8'h00);
        ask(ISR_TGT_SPOLL, 1'b0, 3'h0, {6'h00, cidle, 1'b1});
        repeat (4) @(posedge core_clk);
        stop_test();
    end
endmodule : isr_top_tb
`default_nettype wire
